// >>> include/pmmsi_pkg.sv
// Offsets, field positions, reset values and carriers for the PM/MSI register bank
package pmmsi_pkg;
   // Configuration dword offsets (byte addresses)
   localparam logic [7:0] PMMSI_OFS_PM_CSR = 8'h44;
   localparam logic [7:0] PMMSI_OFS_MSI_CTL = 8'h4c;
   localparam logic [7:0] PMMSI_OFS_MSI_ADDR = 8'h50;
   localparam logic [7:0] PMMSI_OFS_MSI_UADDR = 8'h54;
   // Power-management word field positions
   localparam int PMMSI_POS_PSTATE = 0;
   localparam int PMMSI_POS_NO_SOFT = 3;
   localparam int PMMSI_POS_WAKE_EN = 8;
   localparam int PMMSI_POS_DSEL = 9;
   localparam int PMMSI_POS_DATA = 24;
   localparam int PMMSI_POS_SCALE = 13;
   localparam int PMMSI_POS_WAKE_STS = 15;
   localparam int PMMSI_POS_BRIDGE = 16;
   // Message control field positions
   localparam int PMMSI_POS_CAP_ID = 0;
   localparam int PMMSI_POS_NEXT = 8;
   localparam int PMMSI_POS_MSI_EN = 16;
   localparam int PMMSI_POS_MME = 20;
   localparam int PMMSI_POS_ADDR64 = 23;
   localparam int PMMSI_POS_MMC = 17;
   // Constant and reset values
   localparam logic [1:0] PMMSI_D0 = 2'h0;
   localparam logic [1:0] PMMSI_D3HOT = 2'h3;
   localparam logic [1:0] PMMSI_PSTATE_RST = 2'h0;
   localparam logic PMMSI_NO_SOFT_RST = 1'b1;
   localparam logic [7:0] PMMSI_DATA_RST = 8'h00;
   localparam logic [7:0] PMMSI_CAP_ID = 8'h05;
   localparam logic [7:0] PMMSI_NEXT_PTR = 8'h64;
   localparam logic PMMSI_ADDR64_CAP = 1'b1;
   localparam logic [29:0] PMMSI_ADDR_RST = 30'h0000_0000;
   localparam logic [31:0] PMMSI_UADDR_RST = 32'h0000_0000;
   localparam logic PMMSI_WAKE_EN_RST = 1'b0;
   localparam logic [3:0] PMMSI_DSEL_RST = 4'h0;
   localparam logic PMMSI_MSI_EN_RST = 1'b0;
   localparam logic [2:0] PMMSI_MME_RST = 3'h0;

   // Configuration access from the link core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } pmmsi_cfg_req_t;

   // Preload of strap-like defaults (SMBus, I2C or EEPROM)
   typedef struct packed {
      logic load;
      logic no_soft_reset;
      logic [7:0] data_byte;
   } pmmsi_preload_t;

   // MSI target handed to the interrupt logic
   typedef struct packed {
      logic enable;
      logic [63:0] addr;
      logic [2:0] mme;
   } pmmsi_msi_t;
endpackage

// >>> rtl/pmmsi_regs.sv
// PM control/status and Msi_capability_header bank for one switch port
`timescale 1ns/1ns
// Contract
// - Two-bit power state, reset D0
// - D3 to D0 write fires port hot reset
// - No-soft-reset bit 3, reset 1, preloadable
// - Bit 8 wake enable drives wake message
// - Data scale and wake status read zero
// - Data byte 31:24 reset 00h, preloadable
// - MSI header reads 05h and 64h
// - MSI enable selects MSI over INTx
// - 64-bit address capable bit reads one
// - Message address bits 31:2 read-write, zero
// - Upper address used only if 64-bit capable
module pmmsi_regs #(
   parameter bit IS_DOWNSTREAM = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Configuration access
   input wire pmmsi_pkg::pmmsi_cfg_req_t cfg_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_ack_o,
   // Default preload
   input wire pmmsi_pkg::pmmsi_preload_t preload_i,
   // Port control
   input wire logic intx_req_i,
   output logic port_hot_reset_o,
   output logic internal_reset_o,
   output logic downstream_reset_out_o,
   output logic wake_event_message_o,
   output logic intx_o,
   output logic [1:0] power_state_o,
   output logic [3:0] data_select_o,
   output pmmsi_pkg::pmmsi_msi_t msi_o
);
   import pmmsi_pkg::*;

   // One request per cycle, answered a cycle later with ack and read data.
   // Writes honour byte enables lane by lane. The internal reset pulse goes
   // to the port logic, which owns what it clears; this bank keeps its
   // fields, so software sees the power state it just wrote.

   // Stored fields
   logic [1:0] pstate_reg, pstate_next;
   logic no_soft_reg, no_soft_next;
   logic wake_en_reg, wake_en_next;
   logic [3:0] dsel_reg, dsel_next;
   logic [7:0] data_reg, data_next;
   logic msi_en_reg, msi_en_next;
   logic [2:0] mme_reg, mme_next;
   logic [29:0] addr_reg, addr_next;
   logic [31:0] uaddr_reg, uaddr_next;
   // Side-effect pulses and the read answer
   logic hot_reg, hot_next;
   logic irst_reg, irst_next;
   logic [31:0] rdata_reg, rdata_next;
   logic ack_reg, ack_next;
   // Read images of the two capability words
   logic [31:0] pm_word, msi_word;

   // Byte-enabled hit on one dword
   // Writes only; reads are decoded by offset alone
   function automatic logic hit(input pmmsi_cfg_req_t r, input logic [7:0] ofs,
                                input int lane);
      hit = r.wr && (r.addr == ofs) && r.be[lane];
   endfunction

   // Read images; reserved bits are zero, hardwired fields read their fixed values
   always_comb begin
      pm_word = 32'h0000_0000;
      pm_word[PMMSI_POS_PSTATE +: 2] = pstate_reg;
      pm_word[PMMSI_POS_NO_SOFT] = no_soft_reg;
      pm_word[PMMSI_POS_WAKE_EN] = wake_en_reg;
      pm_word[PMMSI_POS_DSEL +: 4] = dsel_reg;
      pm_word[PMMSI_POS_DATA +: 8] = data_reg;
      // Scale and wake status are hardwired; no wake status is ever raised
      pm_word[PMMSI_POS_SCALE +: 2] = 2'h0;
      pm_word[PMMSI_POS_WAKE_STS] = 1'b0;
      // Bridge extensions byte has no meaning on this link
      pm_word[PMMSI_POS_BRIDGE +: 8] = 8'h00;
      msi_word = 32'h0000_0000;
      msi_word[PMMSI_POS_CAP_ID +: 8] = PMMSI_CAP_ID;
      msi_word[PMMSI_POS_NEXT +: 8] = PMMSI_NEXT_PTR;
      msi_word[PMMSI_POS_MSI_EN] = msi_en_reg;
      msi_word[PMMSI_POS_MME +: 3] = mme_reg;
      msi_word[PMMSI_POS_ADDR64] = PMMSI_ADDR64_CAP;
      // Single vector only, so multiple message capable reads zero
      msi_word[PMMSI_POS_MMC +: 3] = 3'h0;
   end

   // Next-state for all writable fields and side effects
   // Fields hold unless the preload or a lane below overrides them; pulses default low
   always_comb begin
      pstate_next = pstate_reg;
      no_soft_next = no_soft_reg;
      wake_en_next = wake_en_reg;
      dsel_next = dsel_reg;
      data_next = data_reg;
      msi_en_next = msi_en_reg;
      mme_next = mme_reg;
      addr_next = addr_reg;
      uaddr_next = uaddr_reg;
      hot_next = 1'b0;
      irst_next = 1'b0;
      // Preload replaces read-only defaults; software cannot touch them
      if (preload_i.load) begin
         no_soft_next = preload_i.no_soft_reset;
         data_next = preload_i.data_byte;
      end
      if (hit(cfg_i, PMMSI_OFS_PM_CSR, 0)) begin
         pstate_next = cfg_i.wdata[PMMSI_POS_PSTATE +: 2];
         // Hot reset on D3 to D0; reset pin stays quiet
         // Writes that keep D3, or move among D0 to D2, are silent
         if (pstate_reg == PMMSI_D3HOT &&
             cfg_i.wdata[PMMSI_POS_PSTATE +: 2] == PMMSI_D0) begin
            hot_next = 1'b1;
            // Soft reset only while the skip bit is clear
            irst_next = ~no_soft_reg;
         end
      end
      if (hit(cfg_i, PMMSI_OFS_PM_CSR, 1)) begin
         wake_en_next = cfg_i.wdata[PMMSI_POS_WAKE_EN];
         dsel_next = cfg_i.wdata[PMMSI_POS_DSEL +: 4];
      end
      // MSI registers exist on downstream ports only
      if (IS_DOWNSTREAM) begin
         if (hit(cfg_i, PMMSI_OFS_MSI_CTL, 2)) begin
            msi_en_next = cfg_i.wdata[PMMSI_POS_MSI_EN];
            // Enable field kept for software, though one vector is sent
            mme_next = cfg_i.wdata[PMMSI_POS_MME +: 3];
         end
         // Bits 1:0 are reserved, so lane 0 keeps only 7:2
         for (int l = 0; l < 4; l++) begin
            if (hit(cfg_i, PMMSI_OFS_MSI_ADDR, l)) begin
               if (l == 0) begin
                  addr_next[5:0] = cfg_i.wdata[7:2];
               end else begin
                  addr_next[l*8-2 +: 8] = cfg_i.wdata[l*8 +: 8];
               end
            end
            // Upper half of a 64-bit message target
            if (hit(cfg_i, PMMSI_OFS_MSI_UADDR, l)) begin
               uaddr_next[l*8 +: 8] = cfg_i.wdata[l*8 +: 8];
            end
         end
      end
   end

   // Read answer one cycle after the access
   // Writes are acknowledged too, with zero data, so the host never waits
   always_comb begin
      rdata_next = 32'h0000_0000;
      ack_next = cfg_i.rd | cfg_i.wr;
      // Unmapped offsets read zero rather than stall the link
      if (cfg_i.rd) begin
         case (cfg_i.addr)
            PMMSI_OFS_PM_CSR: rdata_next = pm_word;
            PMMSI_OFS_MSI_CTL: rdata_next = IS_DOWNSTREAM ? msi_word : 32'h0000_0000;
            PMMSI_OFS_MSI_ADDR: rdata_next = IS_DOWNSTREAM ? {addr_reg, 2'b00} : 32'h0;
            PMMSI_OFS_MSI_UADDR: rdata_next = IS_DOWNSTREAM ? uaddr_reg : 32'h0;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // State registers
   // Reset restores hardware defaults; a preload must be strobed again after it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pstate_reg <= PMMSI_PSTATE_RST;
         no_soft_reg <= PMMSI_NO_SOFT_RST;
         wake_en_reg <= PMMSI_WAKE_EN_RST;
         dsel_reg <= PMMSI_DSEL_RST;
         data_reg <= PMMSI_DATA_RST;
         msi_en_reg <= PMMSI_MSI_EN_RST;
         mme_reg <= PMMSI_MME_RST;
         addr_reg <= PMMSI_ADDR_RST;
         uaddr_reg <= PMMSI_UADDR_RST;
         hot_reg <= 1'b0;
         irst_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         ack_reg <= 1'b0;
      end else begin
         pstate_reg <= pstate_next;
         no_soft_reg <= no_soft_next;
         wake_en_reg <= wake_en_next;
         dsel_reg <= dsel_next;
         data_reg <= data_next;
         msi_en_reg <= msi_en_next;
         mme_reg <= mme_next;
         addr_reg <= addr_next;
         uaddr_reg <= uaddr_next;
         hot_reg <= hot_next;
         irst_reg <= irst_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
      end
   end

   // Outputs
   assign cfg_rdata_o = rdata_reg;
   assign cfg_ack_o = ack_reg;
   assign port_hot_reset_o = hot_reg;
   assign internal_reset_o = irst_reg;
   // The power-state path never pulls the downstream reset pin
   assign downstream_reset_out_o = 1'b0;
   assign wake_event_message_o = wake_en_reg;
   // Current state and data select for the port's power logic
   assign power_state_o = pstate_reg;
   assign data_select_o = dsel_reg;
   // INTx is silenced while MSI is in use
   assign intx_o = intx_req_i & ~msi_en_reg;
   // One driver for the whole carrier; members driven apart count as
   // several drivers on one variable in some tools
   assign msi_o = '{
      enable: msi_en_reg,
      // Upper half only counts when 64-bit capable
      addr: {(PMMSI_ADDR64_CAP ? uaddr_reg : 32'h0000_0000), addr_reg, 2'b00},
      mme: mme_reg
   };
endmodule // pmmsi_regs

// >>> tb/pmmsi_regs_asserts.sv
// Port assertions for the PM/MSI register bank
`timescale 1ns/1ns
module pmmsi_regs_asserts
   import pmmsi_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched ports
   input wire pmmsi_pkg::pmmsi_cfg_req_t cfg_i,
   input wire logic intx_req_i,
   input wire logic port_hot_reset_o,
   input wire logic internal_reset_o,
   input wire logic downstream_reset_out_o,
   input wire logic wake_event_message_o,
   input wire logic intx_o,
   input wire logic [1:0] power_state_o,
   input wire pmmsi_pkg::pmmsi_msi_t msi_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Writes to the power word, to message control and to the message address
   wire logic pm_wr = cfg_i.wr && cfg_i.addr == 8'h44;
   wire logic mc_wr = cfg_i.wr && cfg_i.addr == 8'h4c && cfg_i.be[2];
   wire logic pm_wr0 = pm_wr && cfg_i.be[0];
   wire logic pm_wr1 = pm_wr && cfg_i.be[1];
   wire logic ad_wr = cfg_i.wr && cfg_i.addr == 8'h50 && cfg_i.be[3];
   wire logic d3_d0 = pm_wr0 && cfg_i.wdata[1:0] == 2'h0 && power_state_o == 2'h3;
   pstate_wr_a: assert property (pm_wr0 |=> power_state_o == $past(cfg_i.wdata[1:0]))
      else $error("power state not written");
   hot_rst_a: assert property (d3_d0 |=> port_hot_reset_o)
      else $error("no hot reset after D3 to D0");
   hot_cause_a: assert property (port_hot_reset_o |-> $past(power_state_o) == 2'h3)
      else $error("hot reset without D3");
   no_dnrst_a: assert property (!downstream_reset_out_o)
      else $error("downstream reset driven");
   soft_rst_a: assert property (internal_reset_o |-> port_hot_reset_o)
      else $error("internal reset alone");
   wake_en_a: assert property (pm_wr1 |=> wake_event_message_o == $past(cfg_i.wdata[8]))
      else $error("wake enable wrong");
   intx_gate_a: assert property (intx_o == (intx_req_i && !msi_o.enable))
      else $error("intx not gated");
   msi_en_a: assert property (mc_wr |=> msi_o.enable == $past(cfg_i.wdata[16]))
      else $error("msi enable wrong");
   addr_low_a: assert property (msi_o.addr[1:0] == 2'h0)
      else $error("msi address not aligned");
   addr_wr_a: assert property (ad_wr |=> msi_o.addr[31:24] == $past(cfg_i.wdata[31:24]))
      else $error("msi address not written");
   // Main scenarios
   hot_c: cover property (d3_d0);
   soft_c: cover property (internal_reset_o);
   msi_c: cover property (msi_o.enable);
endmodule // pmmsi_regs_asserts
bind pmmsi_regs pmmsi_regs_asserts u_pmmsi_regs_asserts (.clk_i(clk_i), .rst_i(rst_i),
   .cfg_i(cfg_i), .intx_req_i(intx_req_i), .port_hot_reset_o(port_hot_reset_o),
   .internal_reset_o(internal_reset_o), .downstream_reset_out_o(downstream_reset_out_o),
   .wake_event_message_o(wake_event_message_o), .intx_o(intx_o),
   .power_state_o(power_state_o), .msi_o(msi_o));

// >>> tb/pmmsi_host.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ns
module pmmsi_host
   import pmmsi_pkg::*;
(
   // Clock and answer
   input wire logic clk_i,
   input wire logic cfg_ack_i,
   input wire logic [31:0] cfg_rdata_i,
   // Request
   output pmmsi_pkg::pmmsi_cfg_req_t cfg_o
);
   initial cfg_o = '0;
   // One-cycle request; the answer lands one cycle after it is taken
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
      input logic [31:0] d, output logic k, output logic [31:0] q);
      @(negedge clk_i);
      cfg_o = '{rd: !w, wr: w, addr: a, be: b, wdata: d};
      @(negedge clk_i);
      // Idle lines flip so stale values are never mistaken
      cfg_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~b, wdata: ~d};
      k = cfg_ack_i;
      q = cfg_rdata_i;
   endtask
endmodule // pmmsi_host

// >>> tb/pmmsi_regs_tb.sv
// Self-checking bench for the PM/MSI register bank
`timescale 1ns/1ns
module pmmsi_regs_tb;
   import pmmsi_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   pmmsi_cfg_req_t cfg;
   pmmsi_preload_t pre = '0;
   pmmsi_msi_t msi;
   logic [31:0] rdata;
   logic [31:0] q;
   logic ack, hot, irst, drst, wake, intx;
   logic intx_req = 1'b1;
   logic [1:0] pst;
   logic [3:0] dsel;
   int n_errors = 0;
   int n_checks = 0;
   initial forever #4 clk_i = ~clk_i;
   pmmsi_host u_pmmsi_host (.clk_i(clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdata), .cfg_o(cfg));
   pmmsi_regs u_pmmsi_regs (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .cfg_rdata_o(rdata),
      .cfg_ack_o(ack), .preload_i(pre), .intx_req_i(intx_req), .port_hot_reset_o(hot),
      .internal_reset_o(irst), .downstream_reset_out_o(drst), .wake_event_message_o(wake),
      .intx_o(intx), .power_state_o(pst), .data_select_o(dsel), .msi_o(msi));
   // Compare and count
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
      end
   endtask
   // One access; an answer must come back one cycle later
   task automatic acc(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
      input logic w);
      logic k;
      u_pmmsi_host.xfer(w, a, b, d, k, q);
      chk(k, 1'b1);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      acc(a, 4'h0, 32'h0, 1'b0);
      chk(q, e);
   endtask
   // Reset values
   task automatic t_reset();
      rdchk(8'h44, 32'h0000_0008);
      rdchk(8'h4c, 32'h0080_6405);
      rdchk(8'h50, 32'h0);
      rdchk(8'h54, 32'h0);
   endtask
   // Power word: fixed bits, D3 to D0 with and without soft reset, preload
   task automatic t_pm();
      acc(8'h44, 4'hf, 32'hffff_ffff, 1'b1);
      rdchk(8'h44, 32'h0000_1f0b);
      chk({wake, dsel, pst}, {1'b1, 4'hf, 2'h3});
      acc(8'h44, 4'h1, 32'h0, 1'b1);
      chk({hot, irst, drst, pst}, 5'b10000);
      pre = '{load: 1'b1, no_soft_reset: 1'b0, data_byte: 8'ha5};
      acc(8'h44, 4'h1, 32'h3, 1'b1);
      pre.load = 1'b0;
      acc(8'h44, 4'h1, 32'h0, 1'b1);
      chk({hot, irst, drst}, 3'b110);
      acc(8'h44, 4'h0, 32'h0, 1'b0);
      chk({q[31:24], q[3:0]}, {8'ha5, 4'h0});
   endtask
   // MSI control, addresses, unmapped place
   task automatic t_msi();
      acc(8'h4c, 4'hf, 32'hffff_ffff, 1'b1);
      rdchk(8'h4c, 32'h00f1_6405);
      chk({msi.enable, intx}, 2'b10);
      acc(8'h50, 4'hf, 32'hffff_ffff, 1'b1);
      acc(8'h54, 4'hf, 32'h1234_5678, 1'b1);
      rdchk(8'h50, 32'hffff_fffc);
      chk(msi.addr, 64'h1234_5678_ffff_fffc);
      rdchk(8'h60, 32'h0);
      acc(8'h4c, 4'h4, 32'h0, 1'b1);
      chk({msi.enable, intx}, 2'b01);
      // INTx follows its request once MSI is off
      intx_req = 1'b0;
      @(negedge clk_i);
      chk(intx, 1'b0);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Watchdog in case an access hangs
   initial begin
      #100000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      t_reset();
      t_pm();
      t_msi();
      report_and_stop();
   end
endmodule // pmmsi_regs_tb
